// File: logic/flic_pkg.sv
package flic_pkg;

	// ------------------------------------------------------------
	// Sizes and source numbering
	// ------------------------------------------------------------
	localparam int NUM_SOURCES = 6;
	localparam int NUM_LEVELS = 4;
	localparam logic [2:0] SRC_EXT0 = 3'h0;
	localparam logic [2:0] SRC_TIMER0 = 3'h1;
	localparam logic [2:0] SRC_EXT1 = 3'h2;
	localparam logic [2:0] SRC_TIMER1 = 3'h3;
	localparam logic [2:0] SRC_SERIAL = 3'h4;
	localparam logic [2:0] SRC_TIMER2 = 3'h5;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_ENABLE_MASK = 8'ha8;
	localparam logic [7:0] IDX_PRIORITY_HIGH = 8'hb7;
	localparam logic [7:0] IDX_PRIORITY_LOW = 8'hb8;
	localparam logic [7:0] IDX_REQUEST_FLAGS = 8'hc0;
	localparam logic [7:0] IDX_EXT_MODE = 8'hc1;
	localparam logic [7:0] IDX_SERVICE = 8'hc2;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'hc4;
	localparam logic [7:0] IDX_EVENT_MASK = 8'hc5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_GLOBAL_ENABLE = 7;
	localparam int FLAG_EXT0 = 0;
	localparam int FLAG_TIMER0 = 1;
	localparam int FLAG_EXT1 = 2;
	localparam int FLAG_TIMER1 = 3;
	localparam int FLAG_SERIAL_RX = 4;
	localparam int FLAG_SERIAL_TX = 5;
	localparam int FLAG_TIMER2_OVF = 6;
	localparam int FLAG_TIMER2_EXT = 7;
	localparam int EV_VECTORED = 0;
	localparam int EV_PREEMPTED = 1;
	localparam int EV_RETURNED = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
	localparam logic [7:0] RST_PRIORITY = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [1:0] RST_EXT_MODE = 2'h0;
	localparam logic [3:0] RST_ACTIVE = 4'h0;
	localparam logic [2:0] RST_EVENTS = 3'h0;

	// ------------------------------------------------------------
	// Fixed vector addresses in polling order
	// ------------------------------------------------------------
	localparam logic [7:0] VECTOR_TABLE [NUM_SOURCES] = '{
		8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b
	};

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [2:0] source;
		logic [1:0] level;
	} flic_winner_t;

	typedef struct packed {
		logic active;
		logic [1:0] level;
	} flic_service_t;

	// Highest level whose routine is in service.
	function automatic flic_service_t flic_top_active(input logic [3:0] active);
		flic_service_t r;
		r = '0;
		for (int l = 0; l < NUM_LEVELS; l++) begin
			if (active[l]) begin
				r.active = 1'b1;
				r.level = 2'(l);
			end
		end
		return r;
	endfunction

endpackage

// File: logic/flic_ext_input.sv
module flic_ext_input
	import flic_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic level_mode,
	input wire logic pin_n,
	input wire logic sw_clear,
	input wire logic hw_clear,
	// Flag
	output logic flag
);

	typedef struct packed {
		logic pin_prev;
		logic flag;
	} flic_ext_state_t;

	flic_ext_state_t s;
	flic_ext_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.pin_prev = pin_n;
		if (level_mode) begin
			next_s.flag = ~pin_n;
		end else begin
			if (sw_clear || hw_clear) begin
				next_s.flag = 1'b0;
			end
			if (s.pin_prev && !pin_n) begin
				next_s.flag = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '{pin_prev: 1'b1, flag: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign flag = s.flag;

endmodule

// File: logic/flic_arbiter.sv
module flic_arbiter
	import flic_pkg::*;
(
	// Requests
	input wire logic [5:0] request,
	input wire logic [7:0] priority_low,
	input wire logic [7:0] priority_high,
	// Result
	output flic_winner_t winner
);

	always_comb begin
		logic [1:0] lvl;
		lvl = 2'h0;
		winner = '0;
		for (int i = 0; i < NUM_SOURCES; i++) begin
			lvl = {priority_high[i], priority_low[i]};
			// Strictly greater keeps the earlier source on a tie.
			if (request[i] && (!winner.valid || lvl > winner.level)) begin
				winner.valid = 1'b1;
				winner.source = 3'(i);
				winner.level = lvl;
			end
		end
	end

endmodule

// File: logic/flic_controller.sv
// The AHB-Lite interface to the registers was decided locally.
module flic_controller
	import flic_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Request sources
	input wire logic EXT0_PIN_N,
	input wire logic EXT1_PIN_N,
	input wire logic TIMER0_OVERFLOW,
	input wire logic TIMER1_OVERFLOW,
	input wire logic TIMER2_OVERFLOW,
	input wire logic TIMER2_EXTERNAL,
	input wire logic SERIAL_RECEIVE,
	input wire logic SERIAL_TRANSMIT,
	// CPU core
	input wire logic CPU_ACK,
	input wire logic CPU_RETURN,
	output logic IRQ_REQ,
	output logic [7:0] IRQ_VECTOR,
	output logic [1:0] IRQ_LEVEL,
	// System interrupt
	output logic IRQ_OUT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic [7:0] interrupt_enable_mask;
		logic [7:0] priority_low_bits;
		logic [7:0] priority_high_bits;
		logic [1:0] ext_level_mode;
		logic timer0_overflow_flag;
		logic timer1_overflow_flag;
		logic timer2_overflow_flag;
		logic timer2_external_flag;
		logic serial_receive_flag;
		logic serial_transmit_flag;
		logic [3:0] active;
		logic [2:0] ev_status;
		logic [2:0] ev_mask;
		logic irq_req;
		logic [2:0] irq_src;
		logic [1:0] irq_level;
		logic [7:0] irq_vector;
		logic irq_out;
		logic ready;
		logic resp;
	} flic_state_t;

	flic_state_t s;
	flic_state_t next_s;

	logic ext0_request_flag;
	logic ext1_request_flag;
	logic [1:0] ext_sw_clear;
	logic [1:0] ext_hw_clear;
	logic [5:0] request;
	flic_winner_t winner;
	flic_service_t in_service;

	// ------------------------------------------------------------
	// External inputs and arbitration
	// ------------------------------------------------------------
	flic_ext_input u_ext0 (
		.clk(CORE_CLK),
		.srst(SRST),
		.level_mode(s.ext_level_mode[0]),
		.pin_n(EXT0_PIN_N),
		.sw_clear(ext_sw_clear[0]),
		.hw_clear(ext_hw_clear[0]),
		.flag(ext0_request_flag)
	);

	flic_ext_input u_ext1 (
		.clk(CORE_CLK),
		.srst(SRST),
		.level_mode(s.ext_level_mode[1]),
		.pin_n(EXT1_PIN_N),
		.sw_clear(ext_sw_clear[1]),
		.hw_clear(ext_hw_clear[1]),
		.flag(ext1_request_flag)
	);

	// Flags are gated only here, so a disabled source keeps its flag.
	always_comb begin
		logic [5:0] raw;
		raw = '0;
		raw[SRC_EXT0] = ext0_request_flag;
		raw[SRC_TIMER0] = s.timer0_overflow_flag;
		raw[SRC_EXT1] = ext1_request_flag;
		raw[SRC_TIMER1] = s.timer1_overflow_flag;
		raw[SRC_SERIAL] = s.serial_receive_flag | s.serial_transmit_flag;
		raw[SRC_TIMER2] = s.timer2_overflow_flag | s.timer2_external_flag;
		request = raw & s.interrupt_enable_mask[5:0]
			& {6{s.interrupt_enable_mask[BIT_GLOBAL_ENABLE]}};
	end

	flic_arbiter u_arbiter (
		.request(request),
		.priority_low(s.priority_low_bits),
		.priority_high(s.priority_high_bits),
		.winner(winner)
	);

	assign in_service = flic_top_active(s.active);

	// ------------------------------------------------------------
	// Bus write decode, shared by the flag clears
	// ------------------------------------------------------------
	logic wr_now;
	logic [7:0] wbyte;
	assign wr_now = s.wr_pend;
	assign wbyte = HWDATA[7:0];
	assign ext_sw_clear[0] = wr_now && s.wr_idx == IDX_REQUEST_FLAGS && wbyte[FLAG_EXT0];
	assign ext_sw_clear[1] = wr_now && s.wr_idx == IDX_REQUEST_FLAGS && wbyte[FLAG_EXT1];
	assign ext_hw_clear[0] = CPU_ACK && s.irq_req && s.irq_src == SRC_EXT0;
	assign ext_hw_clear[1] = CPU_ACK && s.irq_req && s.irq_src == SRC_EXT1;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic ack;
		logic ret;
		logic take;
		logic [2:0] ev_set;
		logic [3:0] act;
		flic_service_t top;
		next_s = s;
		ack = CPU_ACK && s.irq_req;
		ret = CPU_RETURN && in_service.active;
		ev_set = '0;
		take = 1'b0;
		act = 4'h0;
		top = '0;

		// Register writes land in the data phase.
		next_s.wr_pend = 1'b0;
		if (wr_now) begin
			case (s.wr_idx)
				IDX_ENABLE_MASK: begin
					next_s.interrupt_enable_mask = wbyte & 8'hbf;
				end
				IDX_PRIORITY_LOW: begin
					next_s.priority_low_bits = wbyte & 8'h3f;
				end
				IDX_PRIORITY_HIGH: begin
					next_s.priority_high_bits = wbyte & 8'h3f;
				end
				IDX_EXT_MODE: begin
					next_s.ext_level_mode = wbyte[1:0];
				end
				IDX_REQUEST_FLAGS: begin
					next_s.timer0_overflow_flag = s.timer0_overflow_flag & ~wbyte[FLAG_TIMER0];
					next_s.timer1_overflow_flag = s.timer1_overflow_flag & ~wbyte[FLAG_TIMER1];
					next_s.serial_receive_flag = s.serial_receive_flag & ~wbyte[FLAG_SERIAL_RX];
					next_s.serial_transmit_flag = s.serial_transmit_flag & ~wbyte[FLAG_SERIAL_TX];
					next_s.timer2_overflow_flag = s.timer2_overflow_flag
						& ~wbyte[FLAG_TIMER2_OVF];
					next_s.timer2_external_flag = s.timer2_external_flag
						& ~wbyte[FLAG_TIMER2_EXT];
				end
				IDX_EVENT_MASK: begin
					next_s.ev_mask = wbyte[2:0];
				end
				default: begin
				end
			endcase
		end

		// Vectoring clears the timer 0/1 flags; serial and timer 2 stay set.
		if (ack && s.irq_src == SRC_TIMER0) begin
			next_s.timer0_overflow_flag = 1'b0;
		end
		if (ack && s.irq_src == SRC_TIMER1) begin
			next_s.timer1_overflow_flag = 1'b0;
		end

		// A hardware set in the same cycle as a clear wins.
		next_s.timer0_overflow_flag = next_s.timer0_overflow_flag | TIMER0_OVERFLOW;
		next_s.timer1_overflow_flag = next_s.timer1_overflow_flag | TIMER1_OVERFLOW;
		next_s.timer2_overflow_flag = next_s.timer2_overflow_flag | TIMER2_OVERFLOW;
		next_s.timer2_external_flag = next_s.timer2_external_flag | TIMER2_EXTERNAL;
		next_s.serial_receive_flag = next_s.serial_receive_flag | SERIAL_RECEIVE;
		next_s.serial_transmit_flag = next_s.serial_transmit_flag | SERIAL_TRANSMIT;

		// In-service levels: a return pops the top, an ack pushes its level.
		act = s.active;
		if (ret) begin
			act[in_service.level] = 1'b0;
			ev_set[EV_RETURNED] = 1'b1;
		end
		if (ack) begin
			act[s.irq_level] = 1'b1;
			ev_set[EV_VECTORED] = 1'b1;
			ev_set[EV_PREEMPTED] = in_service.active;
		end
		next_s.active = act;

		// Only a level strictly above the top in-service level gets through.
		top = flic_top_active(act);
		take = winner.valid && (!top.active || winner.level > top.level);
		// Holding off one cycle after an ack stops a second vector to the same source.
		next_s.irq_req = take && !ack;
		if (take) begin
			next_s.irq_src = winner.source;
			next_s.irq_level = winner.level;
			next_s.irq_vector = VECTOR_TABLE[winner.source];
		end

		// Event status: write one to clear, set wins.
		if (wr_now && s.wr_idx == IDX_EVENT_STATUS) begin
			next_s.ev_status = s.ev_status & ~wbyte[2:0];
		end
		next_s.ev_status = next_s.ev_status | ev_set;
		next_s.irq_out = |(next_s.ev_status & next_s.ev_mask);

		// Address phase: latch writes, prepare reads from the updated state.
		next_s.ready = 1'b1;
		next_s.resp = 1'b0;
		next_s.rdata = '0;
		if (HSEL && HTRANS[1] && HREADY) begin
			if (HWRITE) begin
				next_s.wr_pend = 1'b1;
				next_s.wr_idx = HADDR[9:2];
			end else begin
				case (HADDR[9:2])
					IDX_ENABLE_MASK: begin
						next_s.rdata[7:0] = next_s.interrupt_enable_mask;
					end
					IDX_PRIORITY_LOW: begin
						next_s.rdata[7:0] = next_s.priority_low_bits;
					end
					IDX_PRIORITY_HIGH: begin
						next_s.rdata[7:0] = next_s.priority_high_bits;
					end
					IDX_EXT_MODE: begin
						next_s.rdata[1:0] = next_s.ext_level_mode;
					end
					IDX_REQUEST_FLAGS: begin
						next_s.rdata[7:0] = {next_s.timer2_external_flag,
							next_s.timer2_overflow_flag, next_s.serial_transmit_flag,
							next_s.serial_receive_flag, next_s.timer1_overflow_flag,
							ext1_request_flag, next_s.timer0_overflow_flag,
							ext0_request_flag};
					end
					IDX_SERVICE: begin
						next_s.rdata[15:0] = {next_s.irq_vector, next_s.irq_req,
							next_s.irq_level, next_s.irq_src, 2'h0};
						next_s.rdata[19:16] = next_s.active;
					end
					IDX_EVENT_STATUS: begin
						next_s.rdata[2:0] = next_s.ev_status;
					end
					IDX_EVENT_MASK: begin
						next_s.rdata[2:0] = next_s.ev_mask;
					end
					default: begin
						next_s.rdata = '0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			s <= '0;
			s.interrupt_enable_mask <= RST_ENABLE_MASK;
			s.priority_low_bits <= RST_PRIORITY;
			s.priority_high_bits <= RST_PRIORITY;
			s.ext_level_mode <= RST_EXT_MODE;
			s.active <= RST_ACTIVE;
			s.ev_status <= RST_EVENTS;
			s.ev_mask <= RST_EVENTS;
			s.ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Zero wait states and no error response, so these flops only hold their reset values.
	assign HRDATA = s.rdata;
	assign HREADYOUT = s.ready;
	assign HRESP = s.resp;
	assign IRQ_REQ = s.irq_req;
	assign IRQ_VECTOR = s.irq_vector;
	assign IRQ_LEVEL = s.irq_level;
	assign IRQ_OUT = s.irq_out;

endmodule

// File: bench/flic_controller_props.sv
module flic_controller_props
	import flic_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Bus
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// CPU side
	input wire logic CPU_ACK,
	input wire logic CPU_RETURN,
	input wire logic IRQ_REQ,
	input wire logic [7:0] IRQ_VECTOR,
	input wire logic [1:0] IRQ_LEVEL,
	input wire logic IRQ_OUT
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----
	// In-service shadow
	// ----
	logic [3:0] svc;
	logic [3:0] next_svc;
	logic rd_take;

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;

	// A return pops only the highest level, so the shadow must unwind one step at a time.
	always_comb begin
		next_svc = svc;
		for (int l = 0; l < 4; l++) begin
			if (CPU_RETURN && svc[l] && (svc >> (l + 1)) == 4'h0) next_svc[l] = 1'b0;
		end
		if (CPU_ACK && IRQ_REQ) next_svc[IRQ_LEVEL] = 1'b1;
	end

	always_ff @(posedge CORE_CLK) begin
		svc <= SRST ? 4'h0 : next_svc;
	end

	ack_drop_a: assert property (CPU_ACK && IRQ_REQ |=> !IRQ_REQ)
		else $error("offer still up after acknowledge");
	svc_order_a: assert property (IRQ_REQ |-> (svc >> IRQ_LEVEL) == 4'h0)
		else $error("offer at or below a level in service");
	vec_map_a: assert property (IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3
		&& IRQ_VECTOR[7:6] == 2'h0 && IRQ_VECTOR[5:3] < 3'h6)
		else $error("vector outside the fixed table");
	bus_ready_a: assert property (HREADYOUT)
		else $error("wait state inserted");
	bus_okay_a: assert property (!HRESP)
		else $error("error response");
	rd_upper_a: assert property (rd_take && HADDR[9:2] != IDX_SERVICE
		|=> HRDATA[31:8] == 24'h0)
		else $error("upper read bits not zero");
	rd_service_a: assert property (rd_take && HADDR[9:2] == IDX_SERVICE
		|=> HRDATA[31:20] == 12'h0 && HRDATA[1:0] == 2'h0)
		else $error("service read has stray bits");
	rd_idle_a: assert property (!rd_take |=> HRDATA == 32'h0)
		else $error("read data outside data phase");
	reset_out_a: assert property ($fell(SRST) |-> !IRQ_REQ && !IRQ_OUT && HRDATA == 32'h0)
		else $error("outputs not cleared by reset");
	nest_c: cover property (CPU_ACK && IRQ_REQ && svc != 4'h0);
endmodule

bind flic_controller flic_controller_props props_u (.CORE_CLK, .SRST, .HSEL, .HADDR, .HTRANS,
	.HWRITE,
	.HREADY, .HRDATA, .HREADYOUT, .HRESP, .CPU_ACK, .CPU_RETURN, .IRQ_REQ, .IRQ_VECTOR,
	.IRQ_LEVEL, .IRQ_OUT);

// File: bench/flic_cpu_model.sv
module flic_cpu_model
	import flic_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Controller side
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	output logic cpu_ack,
	output logic cpu_return,
	// Bench control
	input wire logic ack_on,
	input wire logic [3:0] ack_wait,
	input wire logic ret_req,
	output logic [7:0] taken_vec,
	output logic [7:0] taken_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] wait_cnt;

	// The vector is latched at the edge that takes the acknowledge, not when it is raised.
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_ack <= 1'b0;
			cpu_return <= 1'b0;
			wait_cnt <= 4'h0;
			taken_vec <= 8'h00;
			taken_n <= 8'h00;
		end else begin
			cpu_return <= ret_req;
			cpu_ack <= 1'b0;
			wait_cnt <= 4'h0;
			if (cpu_ack && irq_req) begin
				taken_vec <= irq_vector;
				taken_n <= taken_n + 8'h01;
			end else if (irq_req && ack_on && wait_cnt >= ack_wait) begin
				cpu_ack <= 1'b1;
			end else if (irq_req && ack_on) begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

// File: bench/flic_controller_tb_top.sv
module flic_controller_tb_top
	import flic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0] flag;
		logic [7:0] en;
		logic req;
		logic [7:0] vec;
		logic [7:0] after;
	} flic_row_t;

	logic clk, srst, hsel, hwrite, ack_on, ret_req;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, irq_level;
	logic hreadyout, hresp, irq_req, irq_out, cpu_ack, cpu_return;
	logic [7:0] irq_vector, taken_vec, taken_n, src;
	logic [3:0] ack_wait;
	int failures, checks_done;
	logic [7:0] rst_idx [6] = '{IDX_ENABLE_MASK, IDX_PRIORITY_HIGH, IDX_PRIORITY_LOW,
		IDX_REQUEST_FLAGS, IDX_SERVICE, IDX_EVENT_STATUS};
	flic_row_t rows [10] = '{'{8'h01, 8'h81, 1'b1, 8'h03, 8'h00},
		'{8'h02, 8'h82, 1'b1, 8'h0b, 8'h00}, '{8'h04, 8'h84, 1'b1, 8'h13, 8'h00},
		'{8'h08, 8'h88, 1'b1, 8'h1b, 8'h00}, '{8'h10, 8'h90, 1'b1, 8'h23, 8'h10},
		'{8'h20, 8'h90, 1'b1, 8'h23, 8'h20}, '{8'h40, 8'ha0, 1'b1, 8'h2b, 8'h40},
		'{8'h80, 8'ha0, 1'b1, 8'h2b, 8'h80}, '{8'h02, 8'h02, 1'b0, 8'h00, 8'h02},
		'{8'h08, 8'hb7, 1'b0, 8'h00, 8'h08}};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	flic_controller dut_u (.CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXT0_PIN_N(!src[0]),
		.EXT1_PIN_N(!src[2]), .TIMER0_OVERFLOW(src[1]), .TIMER1_OVERFLOW(src[3]),
		.TIMER2_OVERFLOW(src[6]), .TIMER2_EXTERNAL(src[7]), .SERIAL_RECEIVE(src[4]),
		.SERIAL_TRANSMIT(src[5]), .CPU_ACK(cpu_ack), .CPU_RETURN(cpu_return),
		.IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_LEVEL(irq_level), .IRQ_OUT(irq_out));

	flic_cpu_model cpu_u (.clk(clk), .srst(srst), .irq_req(irq_req), .irq_vector(irq_vector),
		.cpu_ack(cpu_ack), .cpu_return(cpu_return), .ack_on(ack_on), .ack_wait(ack_wait),
		.ret_req(ret_req), .taken_vec(taken_vec), .taken_n(taken_n));

	// ----
	// Tasks
	// ----
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
		end
	endtask

	task automatic hang(input logic cond, inout int n);
		n++;
		if (cond && n > 20) begin
			failures++;
			$display("unexpected at %0t: wait ran out", $time);
			end_sim();
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			hang(1'b1, n);
			@(posedge clk);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp, what);
	endtask

	task automatic take(input logic [7:0] vec, input string what);
		logic [7:0] n0;
		int n;
		n0 = taken_n;
		n = 0;
		ack_on <= 1'b1;
		@(posedge clk);
		while (taken_n === n0) begin
			hang(1'b1, n);
			@(posedge clk);
		end
		ack_on <= 1'b0;
		chk({24'h0, taken_vec}, {24'h0, vec}, what);
	endtask

	task automatic pulse(input logic [7:0] b);
		src <= b;
		@(posedge clk);
		src <= 8'h00;
		repeat (3) @(posedge clk);
	endtask

	task automatic ret();
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		srst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata, src, ack_on, ack_wait, ret_req} = '0;
		failures = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		foreach (rst_idx[i]) rdc(rst_idx[i], 32'h0, "reset value");
		bus(1'b1, IDX_ENABLE_MASK, 32'hff);
		rdc(IDX_ENABLE_MASK, 32'hbf, "enable bits");
		bus(1'b1, IDX_PRIORITY_HIGH, 32'hff);
		rdc(IDX_PRIORITY_HIGH, 32'h3f, "high priority bits");
		bus(1'b1, 8'h10, 32'hff);
		rdc(8'h10, 32'h0, "unmapped");
		bus(1'b1, IDX_PRIORITY_HIGH, 32'h0);
		foreach (rows[i]) begin
			bus(1'b1, IDX_ENABLE_MASK, {24'h0, rows[i].en});
			pulse(rows[i].flag);
			chk({31'h0, irq_req}, {31'h0, rows[i].req}, "offer");
			ack_wait <= 4'(i);
			if (rows[i].req) take(rows[i].vec, "vector");
			if (rows[i].req) ret();
			rdc(IDX_REQUEST_FLAGS, {24'h0, rows[i].after}, "flags kept");
			bus(1'b1, IDX_REQUEST_FLAGS, 32'hff);
		end
		ack_wait <= 4'h0;
		bus(1'b1, IDX_ENABLE_MASK, 32'hbf);
		pulse(8'h58);
		chk({24'h0, irq_vector}, 32'h1b, "tie order");
		bus(1'b1, IDX_PRIORITY_HIGH, 32'h20);
		repeat (2) @(posedge clk);
		chk({30'h0, irq_level}, 32'h2, "level");
		bus(1'b1, IDX_EVENT_MASK, 32'h1);
		take(8'h2b, "higher level wins");
		bus(1'b1, IDX_REQUEST_FLAGS, 32'hc0);
		chk({31'h0, irq_req}, 32'h0, "lower waits");
		chk({31'h0, irq_out}, 32'h1, "event raised");
		bus(1'b1, IDX_EVENT_MASK, 32'h0);
		@(posedge clk);
		chk({31'h0, irq_out}, 32'h0, "event masked");
		bus(1'b1, IDX_EVENT_MASK, 32'h1);
		bus(1'b1, IDX_EVENT_STATUS, 32'h7);
		@(posedge clk);
		chk({31'h0, irq_out}, 32'h0, "event cleared");
		bus(1'b1, IDX_PRIORITY_HIGH, 32'h22);
		bus(1'b1, IDX_PRIORITY_LOW, 32'h02);
		pulse(8'h02);
		chk({30'h0, irq_level}, 32'h3, "preempt level");
		take(8'h0b, "preempt");
		pulse(8'h01);
		chk({31'h0, irq_req}, 32'h0, "pending below");
		ret();
		bus(1'b0, IDX_SERVICE, 32'h0);
		chk({28'h0, rd[19:16]}, 32'h4, "resumed level");
		chk({31'h0, irq_req}, 32'h0, "still pending");
		rdc(IDX_EVENT_STATUS, 32'h7, "vector preempt return events");
		ret();
		chk({24'h0, irq_vector}, 32'h03, "after unwind");
		bus(1'b1, IDX_REQUEST_FLAGS, 32'hff);
		bus(1'b1, IDX_PRIORITY_HIGH, 32'h0);
		bus(1'b1, IDX_PRIORITY_LOW, 32'h0);
		bus(1'b1, IDX_EXT_MODE, 32'h1);
		bus(1'b1, IDX_ENABLE_MASK, 32'h81);
		src <= 8'h01;
		repeat (3) @(posedge clk);
		take(8'h03, "level mode");
		rdc(IDX_REQUEST_FLAGS, 32'h01, "level flag kept");
		src <= 8'h00;
		repeat (3) @(posedge clk);
		rdc(IDX_REQUEST_FLAGS, 32'h00, "level flag follows");
		ret();
		chk({31'h0, irq_out}, 32'h1, "event before reset");
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({31'h0, irq_out}, 32'h0, "event after reset");
		chk({31'h0, irq_req}, 32'h0, "offer after reset");
		rdc(IDX_EVENT_MASK, 32'h0, "mask after reset");
		end_sim();
	end
endmodule
